// File: pkg/cmct_pkg.sv
// Package holding constants and types for the capture/match counter timer.
package cmct_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMCT_OFF_CTRL    = 8'h00;
  localparam logic [7:0] CMCT_OFF_COUNT   = 8'h04;
  localparam logic [7:0] CMCT_OFF_PSMAX   = 8'h08;
  localparam logic [7:0] CMCT_OFF_PSCNT   = 8'h0C;
  localparam logic [7:0] CMCT_OFF_MCTL    = 8'h10;
  localparam logic [7:0] CMCT_OFF_CCTL    = 8'h14;
  localparam logic [7:0] CMCT_OFF_EMCTL   = 8'h18;
  localparam logic [7:0] CMCT_OFF_STATUS  = 8'h1C;
  localparam logic [7:0] CMCT_OFF_MASK    = 8'h20;
  localparam logic [7:0] CMCT_OFF_MATCH0  = 8'h30;
  localparam logic [7:0] CMCT_OFF_CAP0    = 8'h40;
  localparam logic [7:0] CMCT_INST_STRIDE = 8'h80;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CMCT_CTRL_EN     = 0;
  localparam int CMCT_CTRL_RST    = 1;
  localparam int CMCT_CTRL_CNTMD  = 2;
  localparam int CMCT_CTRL_EDGE0  = 2;
  localparam int CMCT_CTRL_SRC    = 4;
  localparam int CMCT_CTRL_CLRCAP = 5;
  localparam int CMCT_CTRL_CLREN  = 6;
  localparam int CMCT_CTRL_CLRED  = 7;
  localparam int CMCT_ST_CAP0     = 4;
  localparam int CMCT_ST_DMA0     = 6;

  // ---------------------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------------------
  localparam logic [31:0] CMCT_RST_WORD = 32'h0000_0000;
  localparam int          CMCT_INSTANCES = 2;
  localparam int          CMCT_MATCHES   = 4;
  localparam int          CMCT_CAPS      = 2;
  localparam int          CMCT_EMOUTS    = 2;

  // Counting mode field: timer, or external edges rising/falling/both.
  typedef enum logic [1:0]
  {
    CMCT_MODE_TIMER = 2'b00,
    CMCT_MODE_RISE  = 2'b01,
    CMCT_MODE_FALL  = 2'b10,
    CMCT_MODE_BOTH  = 2'b11
  } cmct_mode_e;

  // Match pin action.
  typedef enum logic [1:0]
  {
    CMCT_EM_NONE   = 2'b00,
    CMCT_EM_LOW    = 2'b01,
    CMCT_EM_HIGH   = 2'b10,
    CMCT_EM_TOGGLE = 2'b11
  } cmct_em_e;

  // Bus slave phase.
  typedef enum logic [0:0]
  {
    CMCT_BUS_IDLE = 1'b0,
    CMCT_BUS_DATA = 1'b1
  } cmct_bus_e;

endpackage : cmct_pkg

// File: hw/cmct_timer.sv
// One counter/timer instance with prescaler, capture and match logic.
`timescale 1ns/100ps
module cmct_timer
#(
  parameter int NMATCH = 4,
  parameter int NCAP   = 2
)
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic [1:0]        cap_sync_in,
  input  wire logic              wr_in,
  input  wire logic [7:0]        addr_in,
  input  wire logic [31:0]       wdata_in,
  output logic      [31:0]       rdata_out,
  output logic      [1:0]        match_pin_out,
  output logic      [1:0]        dma_req_out,
  output logic                   irq_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0]             ctrl;
    logic [31:0]            count;
    logic [31:0]            psmax;
    logic [31:0]            pscnt;
    logic [11:0]            mctl;
    logic [5:0]             cctl;
    logic [3:0]             emctl;
    logic [5:0]             status;
    logic [5:0]             mask;
    logic [NMATCH-1:0][31:0] match;
    logic [NCAP-1:0][31:0]  cap;
    logic [1:0]             cap_prev;
    logic [1:0]             pin;
    logic [1:0]             dma;
  } cmct_tmr_s;

  cmct_tmr_s st_r;
  cmct_tmr_s st_nxt;

  // ---------------------------------------------------------------------------
  // Combinational update
  // ---------------------------------------------------------------------------
  // Capture edges, count tick, match hits and bus writes in one process.
  // A match is taken only on the count tick after which the count equals
  // the match value, so a stopped counter does not re-raise it each cycle.
  always_comb
  begin
    logic [1:0]        rise;
    logic [1:0]        fall;
    logic [1:0]        cap_ev;
    logic              src;
    logic              tick;
    logic              pre_wrap;
    logic [31:0]       cnt_inc;
    logic [NMATCH-1:0] hit;
    logic              do_rst;
    logic              do_stop;
    logic              cap_clr;
    logic [5:0]        ev;
    rise     = cap_sync_in & ~st_r.cap_prev;
    fall     = ~cap_sync_in & st_r.cap_prev;
    cap_ev   = '0;
    src      = 1'b0;
    tick     = 1'b0;
    pre_wrap = 1'b0;
    cnt_inc  = st_r.count + 32'h0000_0001;
    hit      = '0;
    do_rst   = 1'b0;
    do_stop  = 1'b0;
    cap_clr  = 1'b0;
    ev       = '0;
    st_nxt   = st_r;
    st_nxt.cap_prev = cap_sync_in;
    st_nxt.dma = 2'b00;
    // Capture: each channel has its own rising/falling enable.
    for (int c = 0; c < NCAP; c++)
    begin
      cap_ev[c] = (st_r.cctl[3*c] & rise[c]) | (st_r.cctl[3*c+1] & fall[c]);
      if (cap_ev[c])
      begin
        st_nxt.cap[c] = st_r.count;                            // [R5]
        if (st_r.cctl[3*c+2])
          ev[cmct_pkg::CMCT_ST_CAP0+c] = 1'b1;                 // [R5]
      end
    end
    // Clear on a chosen capture edge, for pulse width measurement.
    if (st_r.ctrl[cmct_pkg::CMCT_CTRL_CLREN])
    begin
      if (st_r.ctrl[cmct_pkg::CMCT_CTRL_CLRED])
        cap_clr = fall[st_r.ctrl[cmct_pkg::CMCT_CTRL_CLRCAP]];
      else
        cap_clr = rise[st_r.ctrl[cmct_pkg::CMCT_CTRL_CLRCAP]];
    end
    // Count source: bus clock, or selected capture input edges.
    src = rise[st_r.ctrl[cmct_pkg::CMCT_CTRL_SRC]] |
          fall[st_r.ctrl[cmct_pkg::CMCT_CTRL_SRC]];
    unique case (cmct_pkg::cmct_mode_e'(
      st_r.ctrl[cmct_pkg::CMCT_CTRL_CNTMD +: 2]))
      cmct_pkg::CMCT_MODE_TIMER: src = 1'b1;                  // [R3]
      cmct_pkg::CMCT_MODE_RISE:
        src = rise[st_r.ctrl[cmct_pkg::CMCT_CTRL_SRC]];        // [R4]
      cmct_pkg::CMCT_MODE_FALL:
        src = fall[st_r.ctrl[cmct_pkg::CMCT_CTRL_SRC]];        // [R4]
      default: src = src;                                       // [R4]
    endcase
    if (st_r.ctrl[cmct_pkg::CMCT_CTRL_EN] &&
        !st_r.ctrl[cmct_pkg::CMCT_CTRL_RST] && src)
    begin
      pre_wrap = (st_r.pscnt == st_r.psmax);
      st_nxt.pscnt = pre_wrap ? 32'h0000_0000
                              : st_r.pscnt + 32'h0000_0001;   // [R13]
      tick = pre_wrap;
    end
    if (tick)
      st_nxt.count = cnt_inc;                                  // [R2]
    // Matches against the new count value.
    for (int m = 0; m < NMATCH; m++)
    begin
      hit[m] = tick && (cnt_inc == st_r.match[m]);
      if (hit[m])
      begin
        if (st_r.mctl[3*m])
          ev[m] = 1'b1;                                        // [R8]
        if (st_r.mctl[3*m+1])
          do_rst = 1'b1;                                       // [R10]
        if (st_r.mctl[3*m+2])
          do_stop = 1'b1;                                      // [R9]
      end
    end
    if (do_rst)
      st_nxt.count = 32'h0000_0000;                            // [R10]
    if (do_stop)
      st_nxt.ctrl[cmct_pkg::CMCT_CTRL_EN] = 1'b0;              // [R9]
    // Match pins follow matches 0 and 1.
    for (int e = 0; e < 2; e++)
    begin
      if (hit[e])
      begin
        case (cmct_pkg::cmct_em_e'(st_r.emctl[2*e +: 2]))
          cmct_pkg::CMCT_EM_LOW:    st_nxt.pin[e] = 1'b0;       // [R11]
          cmct_pkg::CMCT_EM_HIGH:   st_nxt.pin[e] = 1'b1;       // [R11]
          cmct_pkg::CMCT_EM_TOGGLE: st_nxt.pin[e] = ~st_r.pin[e]; // [R11]
          default:                  st_nxt.pin[e] = st_r.pin[e];
        endcase
      end
    end
    // Matches 0 and 1 raise one-cycle DMA requests.
    st_nxt.dma = hit[1:0];                                     // [R12]
    if (cap_clr)
    begin
      st_nxt.count = 32'h0000_0000;                            // [R7]
      st_nxt.pscnt = 32'h0000_0000;                            // [R7]
    end
    // Holding the reset bit keeps count and prescaler at zero, so software
    // can restart a stopped timer from a known point.
    if (st_r.ctrl[cmct_pkg::CMCT_CTRL_RST])
    begin
      st_nxt.count = 32'h0000_0000;
      st_nxt.pscnt = 32'h0000_0000;
    end
    // Register writes; status is write-one-to-clear with set winning.
    if (wr_in)
    begin
      unique case (addr_in)
        cmct_pkg::CMCT_OFF_CTRL:   st_nxt.ctrl  = wdata_in[7:0];
        cmct_pkg::CMCT_OFF_COUNT:  st_nxt.count = wdata_in;
        cmct_pkg::CMCT_OFF_PSMAX:  st_nxt.psmax = wdata_in;
        cmct_pkg::CMCT_OFF_PSCNT:  st_nxt.pscnt = wdata_in;
        cmct_pkg::CMCT_OFF_MCTL:   st_nxt.mctl  = wdata_in[11:0];
        cmct_pkg::CMCT_OFF_CCTL:   st_nxt.cctl  = wdata_in[5:0];
        cmct_pkg::CMCT_OFF_EMCTL:  st_nxt.emctl = wdata_in[3:0];
        cmct_pkg::CMCT_OFF_STATUS:
          st_nxt.status = st_r.status & ~wdata_in[5:0];
        cmct_pkg::CMCT_OFF_MASK:   st_nxt.mask  = wdata_in[5:0];
        cmct_pkg::CMCT_OFF_MATCH0:      st_nxt.match[0] = wdata_in;
        cmct_pkg::CMCT_OFF_MATCH0 + 4:  st_nxt.match[1] = wdata_in;
        cmct_pkg::CMCT_OFF_MATCH0 + 8:  st_nxt.match[2] = wdata_in;
        cmct_pkg::CMCT_OFF_MATCH0 + 12: st_nxt.match[3] = wdata_in;
        default: st_nxt.ctrl = st_nxt.ctrl;
      endcase
    end
    st_nxt.status = st_nxt.status | ev;                        // [R14]
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Synchronous reset brings every field to zero.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Read mux and outputs; the pin and DMA lines come from flip-flops.
  always_comb
  begin
    rdata_out = cmct_pkg::CMCT_RST_WORD;
    case (addr_in)
      cmct_pkg::CMCT_OFF_CTRL:    rdata_out = {24'h00_0000, st_r.ctrl};
      cmct_pkg::CMCT_OFF_COUNT:   rdata_out = st_r.count;
      cmct_pkg::CMCT_OFF_PSMAX:   rdata_out = st_r.psmax;
      cmct_pkg::CMCT_OFF_PSCNT:   rdata_out = st_r.pscnt;
      cmct_pkg::CMCT_OFF_MCTL:    rdata_out = {20'h0_0000, st_r.mctl};
      cmct_pkg::CMCT_OFF_CCTL:    rdata_out = {26'h000_0000, st_r.cctl};
      cmct_pkg::CMCT_OFF_EMCTL:   rdata_out = {28'h000_0000, st_r.emctl};
      cmct_pkg::CMCT_OFF_STATUS:  rdata_out = {26'h000_0000, st_r.status};
      cmct_pkg::CMCT_OFF_MASK:    rdata_out = {26'h000_0000, st_r.mask};
      cmct_pkg::CMCT_OFF_MATCH0:      rdata_out = st_r.match[0];
      cmct_pkg::CMCT_OFF_MATCH0 + 4:  rdata_out = st_r.match[1];
      cmct_pkg::CMCT_OFF_MATCH0 + 8:  rdata_out = st_r.match[2];
      cmct_pkg::CMCT_OFF_MATCH0 + 12: rdata_out = st_r.match[3];
      cmct_pkg::CMCT_OFF_CAP0:        rdata_out = st_r.cap[0];
      cmct_pkg::CMCT_OFF_CAP0 + 4:    rdata_out = st_r.cap[1];
      default: rdata_out = cmct_pkg::CMCT_RST_WORD;
    endcase
  end

  assign match_pin_out = st_r.pin;
  assign dma_req_out   = st_r.dma;
  assign irq_out       = |(st_r.status & st_r.mask);           // [R14]

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_wrap;
    st_r.ctrl[0] && !st_r.ctrl[1] && st_r.ctrl[3:2] == 2'b00
    && st_r.pscnt == st_r.psmax && !wr_in;
  endsequence

  property p_count_step;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    s_wrap ##0 (st_r.mctl == 12'h000 && st_r.ctrl[6] == 1'b0)
    |=> st_r.count == $past(st_r.count) + 32'h0000_0001
        && st_r.pscnt == 32'h0000_0000;
  endproperty
  a_count_step: assert property (p_count_step)                 // [R13]
    else $error("count did not advance on prescale wrap");

  property p_irq;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    irq_out == |(st_r.status & st_r.mask);
  endproperty
  a_irq: assert property (p_irq)                               // [R14]
    else $error("interrupt level wrong");

  property p_stop;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_nxt.count == st_r.match[0] && st_r.mctl[2] && st_r.ctrl[0]
     && st_nxt.count == st_r.count + 32'h0000_0001 && !wr_in
     && !st_r.mctl[1])
    |=> !st_r.ctrl[0] ##1 $stable(st_r.count);
  endproperty
  a_stop: assert property (p_stop)                             // [R9]
    else $error("counter did not stop on match");

  // A falling edge on channel 0 loads the count that stood before it.
  property p_capture;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    st_r.cctl[1] && !cap_sync_in[0] && st_r.cap_prev[0]
    |=> st_r.cap[0] == $past(st_r.count);
  endproperty
  a_capture: assert property (p_capture)                       // [R5]
    else $error("capture register missed the count");

  // A rising edge on capture channel 0, chosen for clearing, zeroes count and prescaler.
  property p_clear_edge;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    st_r.ctrl[cmct_pkg::CMCT_CTRL_CLREN]
    && !st_r.ctrl[cmct_pkg::CMCT_CTRL_CLRED]
    && !st_r.ctrl[cmct_pkg::CMCT_CTRL_CLRCAP]
    && cap_sync_in[0] && !st_r.cap_prev[0] && !wr_in
    |=> st_r.count == 32'h0000_0000 && st_r.pscnt == 32'h0000_0000;
  endproperty
  a_clear_edge: assert property (p_clear_edge)                 // [R7]
    else $error("capture edge did not clear the counter");

  // Without a status write no pending flag may drop.
  property p_sticky;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    !(wr_in && addr_in == cmct_pkg::CMCT_OFF_STATUS)
    |=> (st_r.status & $past(st_r.status)) == $past(st_r.status);
  endproperty
  a_sticky: assert property (p_sticky)                         // [R14]
    else $error("pending flag dropped without a clear");
endmodule : cmct_timer

// File: hw/cmct_top.sv
// AHB-Lite slave holding two capture/match counter timer instances.
`timescale 1ns/100ps
module cmct_top
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic [3:0]  cap_pin_in,
  output logic      [3:0]  match_pin_out,
  output logic      [3:0]  dma_req_out,
  output logic      [1:0]  irq_out
);
// Notes on behaviour
// R1: Two independent timer instances.
// R2: 32-bit count through 32-bit prescaler.
// R3: Timer mode counts bus clock cycles.
// R4: Capture input selectable as count source.
// R5: Two capture channels snapshot count, interrupt.
// R6: Each capture pin feeds one channel.
// R7: Capture event may clear count, prescaler.
// R8: Four match registers with optional interrupt.
// R9: Match may stop the counter.
// R10: Match may reset the counter.
// R11: Two match pins low/high/toggle/hold.
// R12: Two matches issue DMA requests.
// R13: Count steps when prescaler wraps.
// R14: Sticky flags drive interrupt until cleared.

  // ---------------------------------------------------------------------------
  // Pin synchronisers and bus address phase
  // ---------------------------------------------------------------------------
  typedef struct packed
  {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic        act;
    logic        wr;
    logic [7:0]  addr;
    logic        inst;
  } cmct_top_s;

  cmct_top_s st_r;
  cmct_top_s st_nxt;
  logic [1:0][31:0] rd;

  // Address phase capture; data phase write goes to the chosen instance.
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.sync1 = cap_pin_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.act   = hsel_in && hready_in && htrans_in[1];
    if (hsel_in && hready_in && htrans_in[1])
    begin
      st_nxt.wr   = hwrite_in;
      st_nxt.addr = haddr_in[7:0] & 8'h7F;
      st_nxt.inst = haddr_in[7];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------------------
  // Each instance sees its own two capture pins.
  for (genvar i = 0; i < cmct_pkg::CMCT_INSTANCES; i++)
  begin : g_inst
    cmct_timer #(.NMATCH(cmct_pkg::CMCT_MATCHES), .NCAP(cmct_pkg::CMCT_CAPS))
    u_tmr                                                       // [R1]
    (
      .ref_clk_in    (ref_clk_in),
      .rst_b_in      (rst_b_in),
      .cap_sync_in   (st_r.sync2[2*i +: 2]),                     // [R6]
      .wr_in         (st_r.act && st_r.wr && st_r.inst == 1'(i)),
      .addr_in       (st_r.addr),
      .wdata_in      (hwdata_in),
      .rdata_out     (rd[i]),
      .match_pin_out (match_pin_out[2*i +: 2]),
      .dma_req_out   (dma_req_out[2*i +: 2]),
      .irq_out       (irq_out[i])
    );
  end

  // Zero wait states, always OKAY.
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = st_r.act ? rd[st_r.inst] : 32'h0000_0000;

endmodule : cmct_top

// File: testbench/cmct_pin_model.sv
// Behavioural model of the board-side capture pins of the timer.
`timescale 1ns/100ps
module cmct_pin_model
(
  input  wire logic       ref_clk_in,
  output logic      [3:0] cap_pin_out
);
  // Pins idle low; each pin feeds exactly one capture channel.
  initial cap_pin_out = 4'h0;

  // One pulse of hi cycles, then lo quiet cycles; slow or fast by argument.
  // Pins move only right after a rising edge so the synchroniser sees clean
  // levels.
  task automatic pulse(input int ch, input int hi, input int lo);
    @(posedge ref_clk_in);
    cap_pin_out[ch] <= 1'b1;
    repeat (hi) @(posedge ref_clk_in);
    cap_pin_out[ch] <= 1'b0;
    repeat (lo) @(posedge ref_clk_in);
  endtask : pulse
endmodule : cmct_pin_model

// File: testbench/tb_capture_match_counter_timer.sv
// Self-checking testbench for the capture/match counter timer.
`timescale 1ns/100ps
module tb_capture_match_counter_timer;
  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  cap_pin;
  logic [3:0]  match_pin;
  logic [3:0]  dma_req;
  logic [1:0]  irq;
  logic [31:0] rd;
  logic [31:0] m;
  logic [31:0] p;
  logic [31:0] w;
  logic        pin;
  int          n;
  int          mismatches = 0;
  int          compares   = 0;
  int          seed       = 45694;
  cmct_pkg::cmct_em_e em_seq [5] = '{cmct_pkg::CMCT_EM_HIGH,
    cmct_pkg::CMCT_EM_NONE, cmct_pkg::CMCT_EM_TOGGLE,
    cmct_pkg::CMCT_EM_LOW, cmct_pkg::CMCT_EM_TOGGLE};

  // 250 MHz clock.
  always #2 ref_clk = ~ref_clk;

  cmct_top cmct_top_i (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .cap_pin_in(cap_pin),
    .match_pin_out(match_pin), .dma_req_out(dma_req), .irq_out(irq));

  cmct_pin_model cmct_pin_model_i (.ref_clk_in(ref_clk),
    .cap_pin_out(cap_pin));

  // ---------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string what, input logic [31:0] lo,
                         input logic [31:0] hi, input logic [31:0] g);
    compares++;
    if (!(g >= lo && g <= hi) || $isunknown(g))
    begin
      mismatches++;
      $display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, g);
    end
  endtask : chk_rng

  // Waits for hready at a rising edge; a stuck bus ends the run.
  task automatic rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1)
    begin
      chk("hready", 32'h1, {31'h0, hreadyout});
      report_and_stop();
    end
  endtask : rdy

  // One single word transfer: address phase, then data phase.
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : xfer

  function automatic logic [31:0] ra(input int i, input logic [7:0] off);
    return 32'(i) * {24'h0, cmct_pkg::CMCT_INST_STRIDE} + {24'h0, off};
  endfunction : ra

  // Pin level after a match, from the action code and the old level.
  function automatic logic exp_pin(input cmct_pkg::cmct_em_e e,
                                   input logic old);
    case (e)
      cmct_pkg::CMCT_EM_LOW:    return 1'b0;
      cmct_pkg::CMCT_EM_HIGH:   return 1'b1;
      cmct_pkg::CMCT_EM_TOGGLE: return ~old;
      default:                  return old;
    endcase
  endfunction : exp_pin

  task automatic wait_irq(input int b);
    int k;
    k = 0;
    while (irq[b] !== 1'b1 && k < 400)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk("irq raised", 32'h1, {31'h0, irq[b]});
    if (irq[b] !== 1'b1)
      report_and_stop();
  endtask : wait_irq

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 2; i++)
      for (int o = 0; o < 9; o++)
      begin
        xfer(1'b0, ra(i, 8'(o * 4)), 32'h0);
        chk("reset value", cmct_pkg::CMCT_RST_WORD, rd);
      end
    chk("outputs idle", 32'h0, {20'h0, match_pin, dma_req, 2'h0, irq});
    xfer(1'b1, ra(0, 8'h7C), $random(seed));
    xfer(1'b0, ra(0, 8'h7C), 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp okay", 32'h0, {31'h0, hresp});
    $display("reset test done");
    // Stop on match through every pin action, instance 0.
    p = 32'($unsigned($random(seed)) % 4);
    m = 32'h2 + 32'($unsigned($random(seed)) % 8);
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_PSMAX), p);
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_MATCH0), m);
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_MCTL), 32'h5);
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_MASK), 32'h1);
    pin = 1'b0;
    foreach (em_seq[k])
    begin
      xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_EMCTL), {30'h0, em_seq[k]});
      xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_CTRL), 32'h2);
      xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_CTRL), 32'h1);
      wait_irq(0);
      repeat (2) @(posedge ref_clk);
      pin = exp_pin(em_seq[k], pin);
      chk("match pin", {31'h0, pin}, {31'h0, match_pin[0]});
      chk("other irq", 32'h0, {31'h0, irq[1]});
      xfer(1'b0, ra(0, cmct_pkg::CMCT_OFF_COUNT), 32'h0);
      chk("stop count", m, rd);
      xfer(1'b0, ra(0, cmct_pkg::CMCT_OFF_CTRL), 32'h0);
      chk("stop clears enable", 32'h0, rd);
      xfer(1'b0, ra(0, cmct_pkg::CMCT_OFF_STATUS), 32'h0);
      chk("status", 32'h1, rd);
      xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_STATUS), 32'h1);
      xfer(1'b0, ra(0, cmct_pkg::CMCT_OFF_STATUS), 32'h0);
      chk("status cleared", 32'h0, rd);
      chk("irq cleared", 32'h0, {31'h0, irq[0]});
    end
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_MASK), 32'h0);
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_CTRL), 32'h2);
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_CTRL), 32'h1);
    for (int k = 0; k < 60 && rd[0] !== 1'b1; k++)
      xfer(1'b0, ra(0, cmct_pkg::CMCT_OFF_STATUS), 32'h0);
    chk("masked status", 32'h1, rd);
    chk("masked irq", 32'h0, {31'h0, irq[0]});
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_STATUS), 32'h1);
    $display("stop and pin test done");
    // Periodic reset on match 1 with DMA and toggling pin, instance 1.
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_PSMAX), p);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_MATCH0 + 8'h4), m);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_MCTL), 32'h18);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_EMCTL), 32'hC);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_MASK), 32'h2);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_CTRL), 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      pin = match_pin[3];
      n = 0;
      do
      begin
        @(posedge ref_clk);
        n++;
      end
      while (dma_req[3] !== 1'b1 && n < 200);
      if (k == 1)
        chk("period", m * (p + 32'h1), 32'(n));
      if (k == 1)
        chk("pin toggled", {31'h0, ~pin}, {31'h0, match_pin[3]});
    end
    @(posedge ref_clk);
    chk("dma pulse", 32'h0, {31'h0, dma_req[3]});
    chk("periodic irq", 32'h1, {31'h0, irq[1]});
    xfer(1'b0, ra(1, cmct_pkg::CMCT_OFF_COUNT), 32'h0);
    chk_rng("count below match", 32'h0, m - 32'h1, rd);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_CTRL), 32'h0);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_STATUS), 32'h3F);
    $display("periodic test done");
    // Pulse width: clear on rise, capture on fall, channel 0 of inst 1.
    w = 32'h5 + 32'($unsigned($random(seed)) % 36);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_PSMAX), 32'h0);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_MCTL), 32'h0);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_CCTL), 32'h6);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_MASK), 32'h10);
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_CTRL), 32'h41);
    cmct_pin_model_i.pulse(2, int'(w), 8);
    xfer(1'b0, ra(1, cmct_pkg::CMCT_OFF_CAP0), 32'h0);
    chk_rng("pulse width", w - 32'h1, w + 32'h1, rd);
    m = rd;
    xfer(1'b1, ra(1, cmct_pkg::CMCT_OFF_CAP0), 32'hFFFF_FFFF);
    xfer(1'b0, ra(1, cmct_pkg::CMCT_OFF_CAP0), 32'h0);
    chk("capture read only", m, rd);
    xfer(1'b0, ra(1, cmct_pkg::CMCT_OFF_STATUS), 32'h0);
    chk("capture status", 32'h10, rd & 32'h30);
    chk("capture irq", 32'h1, {31'h0, irq[1]});
    $display("capture test done");
    // Counter mode on capture pin 0 for each edge choice, instance 0.
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_MCTL), 32'h0);
    xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_PSMAX), 32'h0);
    for (int md = 1; md < 4; md++)
    begin
      n = 1 + ($unsigned($random(seed)) % 6);
      xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_CTRL), 32'h2);
      xfer(1'b1, ra(0, cmct_pkg::CMCT_OFF_CTRL), 32'(md * 4 + 1));
      repeat (n) cmct_pin_model_i.pulse(0, 3, 3);
      repeat (8) @(posedge ref_clk);
      xfer(1'b0, ra(0, cmct_pkg::CMCT_OFF_COUNT), 32'h0);
      chk("event count", 32'(md == 3 ? 2 * n : n), rd);
    end
    $display("counter test done");
    report_and_stop();
  end

  // Overall guard against a hang.
  initial
  begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule : tb_capture_match_counter_timer
